// >>> logic/sensor_pkg.sv
package sensor_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int CONV_PERIOD_MS = 500;
	localparam int CONV_CYC = CLK_HZ / 1000 * CONV_PERIOD_MS;
	localparam int TIMEOUT_MS = 25;
	localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;

	// ****************************************************************
	// Pointer values, fields and reset values
	// ****************************************************************
	localparam logic [7:0] PTR_TEMP = 8'h00;
	localparam logic [7:0] PTR_CFG = 8'h01;
	localparam logic [7:0] PTR_HYST = 8'h02;
	localparam logic [7:0] PTR_LOW = 8'h03;
	localparam logic [7:0] PTR_HIGH = 8'h04;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam int CFG_SHDN = 0;
	localparam int CFG_FQ = 3;
	localparam int CFG_TODIS = 7;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] HIGH_RST = 16'h2800;
	localparam logic [15:0] LOW_RST = 16'h0500;
	localparam logic [15:0] HYST_RST = 16'h2580;
	localparam logic [12:0] TEMP_RST = 13'h0000;
	localparam int TEMP_LSB = 3;
	localparam int STAT_HIGH = 1;
	localparam int STAT_LOW = 0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum {ST_IDLE, ST_RX, ST_ACKO, ST_TX, ST_ACKI} link_state_t;
	typedef struct packed {
		logic rise;
		logic fall;
		logic start;
		logic stop;
	} bus_evt_t;
endpackage : sensor_pkg

// >>> logic/smbus_temp_sensor_regs.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Convert periodically, newest result always readable
// - Slave only; byte and word reads, writes
// - Strap pins form low address bits
// - Two straps give four addresses
// - Three straps give eight addresses
// - Four straps give sixteen addresses
// - First written byte sets pointer; pointer selects
// - Temperature 16 bits, read only, low unused
// - Two's complement, 0.0625 C per step
// - Configuration is 8 bits, read and write
// - Config: timeout disable, fault queue, shutdown
// - Limit variant adds high, low, hysteresis
// - Limit variant: two low status bits
// - Data line only pulled low, also received
// - Alarm and overheat are open-drain outputs
module smbus_temp_sensor_regs #(
	parameter int NUM_STRAPS = 3,
	parameter logic [6:0] ADDR_FIXED = 7'h40,
	parameter int CONV_CYCLES = sensor_pkg::CONV_CYC,
	parameter int TIMEOUT_CYCLES = sensor_pkg::TIMEOUT_CYC
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_addr_strap_bit0,
	input wire logic i_addr_strap_bit1,
	input wire logic i_addr_strap_bit2,
	input wire logic i_addr_strap_bit3,
	input wire logic [12:0] i_die_temp,
	output logic o_sda,
	output logic o_sda_oe,
	output logic o_alarm,
	output logic o_alarm_oe,
	output logic o_overheat_shutdown_out,
	output logic o_overheat_shutdown_out_oe
);
	// ****************************************************************
	// Parameters and checks
	// ****************************************************************
	localparam bit HAS_LIMITS = (NUM_STRAPS == 3);
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [6:0] STRAP_MASK = 7'((1 << NUM_STRAPS) - 1);

	generate
		if (NUM_STRAPS < 2 || NUM_STRAPS > 4) begin : g_bad_straps
			$error("NUM_STRAPS must be 2, 3 or 4");
		end
		if (CONV_CYCLES < 2 || TIMEOUT_CYCLES < 2) begin : g_bad_counts
			$error("cycle counts must be at least 2");
		end
	endgenerate

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic scl_s1_r, scl_s2_r, scl_d_r;
	logic sda_s1_r, sda_s2_r, sda_d_r;
	logic [3:0] strap_s1_r, strap_s2_r;
	sensor_pkg::bus_evt_t evt;
	logic [6:0] my_addr;

	// Idle bus is high, so reset high to avoid a false start
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s1_r <= i_scl;
			scl_s2_r <= scl_s1_r;
			scl_d_r <= scl_s2_r;
			sda_s1_r <= i_sda;
			sda_s2_r <= sda_s1_r;
			sda_d_r <= sda_s2_r;
		end
	end

	// Straps are static, so they are simply tracked after reset
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			strap_s1_r <= 4'h0;
			strap_s2_r <= 4'h0;
		end else begin
			strap_s1_r <= {i_addr_strap_bit3, i_addr_strap_bit2,
				i_addr_strap_bit1, i_addr_strap_bit0};
			strap_s2_r <= strap_s1_r;
		end
	end

	// Only the straps the variant has reach the address
	assign my_addr = (ADDR_FIXED & ~STRAP_MASK)
		| ({3'h0, strap_s2_r} & STRAP_MASK);

	// Bus events from the second stage and its delayed copy
	assign evt.rise = scl_s2_r & ~scl_d_r;
	assign evt.fall = ~scl_s2_r & scl_d_r;
	assign evt.start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign evt.stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

	// ****************************************************************
	// Serial slave engine
	// ****************************************************************
	sensor_pkg::link_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r, tx_r, ptr_r, cfg_r, msb_hold_r;
	logic [1:0] byte_no_r;
	logic rw_r, sda_oe_r, byte_done, addr_hit, tmo_hit;
	logic ptr_wr, data_wr1, data_wr2;
	logic [15:0] rd_word, high_r, low_r, hyst_r;
	logic [7:0] rd_byte;
	logic [TW-1:0] tmo_cnt_r;
	logic [12:0] temp_r;
	logic stat_high, stat_low;

	assign byte_done = evt.fall && state_r == sensor_pkg::ST_RX
		&& bit_cnt_r == 4'h8;
	assign addr_hit = byte_done && byte_no_r == 2'h0
		&& shift_r[7:1] == my_addr;
	// Write strobes only after a write address
	assign ptr_wr = byte_done && !rw_r && byte_no_r == 2'h1;
	assign data_wr1 = byte_done && !rw_r && byte_no_r == 2'h2;
	assign data_wr2 = byte_done && !rw_r && byte_no_r == 2'h3;

	// Read mux; the low byte is sent only after the high byte
	always_comb begin
		case (ptr_r)
			sensor_pkg::PTR_TEMP: rd_word = HAS_LIMITS
				? {temp_r, 1'b0, stat_high, stat_low}
				: {temp_r, 3'h0};
			sensor_pkg::PTR_HYST: rd_word = HAS_LIMITS ? hyst_r : 16'h0000;
			sensor_pkg::PTR_LOW: rd_word = HAS_LIMITS ? low_r : 16'h0000;
			sensor_pkg::PTR_HIGH: rd_word = HAS_LIMITS ? high_r : 16'h0000;
			default: rd_word = 16'h0000;
		endcase
		if (ptr_r == sensor_pkg::PTR_CFG) begin
			rd_byte = cfg_r;
		end else if (state_r == sensor_pkg::ST_ACKO) begin
			rd_byte = rd_word[15:8];
		end else begin
			rd_byte = rd_word[7:0];
		end
	end

	// Byte framing, acknowledge and transmit; never a bus master
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			state_r <= sensor_pkg::ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			byte_no_r <= 2'h0;
			rw_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (evt.start) begin
			state_r <= sensor_pkg::ST_RX;
			bit_cnt_r <= 4'h0;
			byte_no_r <= 2'h0;
			sda_oe_r <= 1'b0;
		end else if (evt.stop || tmo_hit) begin
			state_r <= sensor_pkg::ST_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
				sensor_pkg::ST_RX: begin
					if (evt.rise) begin
						shift_r <= {shift_r[6:0], sda_s2_r};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (byte_done) begin
						bit_cnt_r <= 4'h0;
						if (byte_no_r != 2'h3) begin
							byte_no_r <= byte_no_r + 2'h1;
						end
						if (byte_no_r != 2'h0 || addr_hit) begin
							sda_oe_r <= 1'b1; // ACK
							state_r <= sensor_pkg::ST_ACKO;
						end else begin
							state_r <= sensor_pkg::ST_IDLE;
						end
						if (byte_no_r == 2'h0) begin
							rw_r <= shift_r[0];
						end
					end
				end
				sensor_pkg::ST_ACKO: begin
					if (evt.fall && rw_r) begin
						tx_r <= rd_byte;
						sda_oe_r <= ~rd_byte[7];
						bit_cnt_r <= 4'h0;
						state_r <= sensor_pkg::ST_TX;
					end else if (evt.fall) begin
						sda_oe_r <= 1'b0;
						state_r <= sensor_pkg::ST_RX;
					end
				end
				sensor_pkg::ST_TX: begin
					if (evt.fall && bit_cnt_r == 4'h7) begin
						sda_oe_r <= 1'b0;
						state_r <= sensor_pkg::ST_ACKI;
					end else if (evt.fall) begin
						tx_r <= {tx_r[6:0], 1'b0};
						sda_oe_r <= ~tx_r[6];
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
				end
				sensor_pkg::ST_ACKI: begin
					if (evt.rise && sda_s2_r) begin
						state_r <= sensor_pkg::ST_IDLE; // Master NACK
					end else if (evt.fall) begin
						tx_r <= rd_byte;
						sda_oe_r <= ~rd_byte[7];
						bit_cnt_r <= 4'h0;
						state_r <= sensor_pkg::ST_TX;
					end
				end
				default: state_r <= sensor_pkg::ST_IDLE;
			endcase
		end
	end

	// Stuck-low clock frees the bus unless timeout is disabled
	always_ff @(posedge i_clock) begin
		if (i_reset || state_r == sensor_pkg::ST_IDLE || scl_s2_r) begin
			tmo_cnt_r <= '0;
		end else if (!tmo_hit) begin
			tmo_cnt_r <= tmo_cnt_r + TW'(1);
		end
	end
	assign tmo_hit = tmo_cnt_r == TW'(TIMEOUT_CYCLES - 1)
		&& !cfg_r[sensor_pkg::CFG_TODIS];

	// ****************************************************************
	// Register file
	// ****************************************************************
	// Word writes land only when the low byte arrives
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ptr_r <= sensor_pkg::PTR_RST;
			cfg_r <= sensor_pkg::CFG_RST;
			msb_hold_r <= 8'h00;
			high_r <= sensor_pkg::HIGH_RST;
			low_r <= sensor_pkg::LOW_RST;
			hyst_r <= sensor_pkg::HYST_RST;
		end else begin
			if (ptr_wr) begin
				ptr_r <= shift_r;
			end
			if (data_wr1 && ptr_r == sensor_pkg::PTR_CFG) begin
				cfg_r <= shift_r;
			end else if (data_wr1) begin
				msb_hold_r <= shift_r;
			end
			if (data_wr2 && HAS_LIMITS) begin
				case (ptr_r)
					sensor_pkg::PTR_HIGH: high_r <= {msb_hold_r, shift_r};
					sensor_pkg::PTR_LOW: low_r <= {msb_hold_r, shift_r};
					sensor_pkg::PTR_HYST: hyst_r <= {msb_hold_r, shift_r};
					default: ;
				endcase
			end
		end
	end

	// ****************************************************************
	// Conversion and limits
	// ****************************************************************
	logic [CW-1:0] conv_cnt_r;
	logic conv_tick, conv_done_r, over_prev_r, alarm_r, overheat_r;
	logic over_high, under_hyst;

	// Counter parks in shutdown so waking restarts a full period
	always_ff @(posedge i_clock) begin
		if (i_reset || conv_tick || cfg_r[sensor_pkg::CFG_SHDN]) begin
			conv_cnt_r <= '0;
		end else begin
			conv_cnt_r <= conv_cnt_r + CW'(1);
		end
	end
	assign conv_tick = conv_cnt_r == CW'(CONV_CYCLES - 1);

	// Newest signed result, 0.0625 C per step
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			temp_r <= sensor_pkg::TEMP_RST;
			conv_done_r <= 1'b0;
		end else begin
			conv_done_r <= conv_tick;
			if (conv_tick) begin
				temp_r <= i_die_temp;
			end
		end
	end

	assign over_high = $signed(temp_r)
		>= $signed(high_r[15:sensor_pkg::TEMP_LSB]);
	assign under_hyst = $signed(temp_r)
		< $signed(hyst_r[15:sensor_pkg::TEMP_LSB]);
	assign stat_high = over_high;
	assign stat_low = $signed(temp_r)
		< $signed(low_r[15:sensor_pkg::TEMP_LSB]);

	// Fault queue needs two hot results in a row before alarming
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			over_prev_r <= 1'b0;
			alarm_r <= 1'b0;
			overheat_r <= 1'b0;
		end else if (conv_done_r) begin
			over_prev_r <= over_high;
			overheat_r <= over_high;
			if (over_high && (over_prev_r || !cfg_r[sensor_pkg::CFG_FQ])) begin
				alarm_r <= 1'b1;
			end else if (under_hyst) begin
				alarm_r <= 1'b0;
			end
		end
	end

	// Open-drain pins: level is always low, enable pulls
	assign o_sda = 1'b0;
	assign o_sda_oe = sda_oe_r;
	assign o_alarm = 1'b0;
	assign o_alarm_oe = alarm_r;
	assign o_overheat_shutdown_out = 1'b0;
	assign o_overheat_shutdown_out_oe = overheat_r;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	sequence s_addr_ok;
		addr_hit;
	endsequence
	sequence s_ack_held;
		sda_oe_r && state_r == sensor_pkg::ST_ACKO;
	endsequence

	AST_CONV_LATCH: assert property (conv_tick |=>
		temp_r == $past(i_die_temp))
		else $error("conversion result not latched");
	AST_SHDN_HOLD: assert property (
		$past(cfg_r[sensor_pkg::CFG_SHDN])
		&& $past(cfg_r[sensor_pkg::CFG_SHDN], 2)
		|-> $stable(temp_r) && !conv_tick)
		else $error("conversion ran in shutdown");
	AST_ADDR_ACK: assert property (s_addr_ok |=> s_ack_held)
		else $error("own address not acknowledged");
	AST_WRONG_ADDR: assert property (
		byte_done && byte_no_r == 2'h0 && shift_r[7:1] != my_addr
		|=> state_r == sensor_pkg::ST_IDLE && !sda_oe_r)
		else $error("foreign address answered");
	AST_PTR_WRITE: assert property (ptr_wr |=>
		ptr_r == $past(shift_r))
		else $error("pointer not loaded from first byte");
	AST_CFG_WRITE: assert property (
		data_wr1 && ptr_r == sensor_pkg::PTR_CFG |=> cfg_r == $past(shift_r))
		else $error("configuration write lost");
	AST_MSB_FIRST: assert property (
		evt.fall && rw_r && state_r == sensor_pkg::ST_ACKO
		&& ptr_r == sensor_pkg::PTR_TEMP |=> tx_r == $past(rd_word[15:8]))
		else $error("high byte not sent first");
	AST_TEMP_FMT: assert property (
		ptr_r == sensor_pkg::PTR_TEMP |-> !rd_word[2]
		&& rd_word[15:3] == temp_r)
		else $error("temperature word format wrong");
	AST_SDA_RELEASE: assert property (
		evt.stop |=> !o_sda_oe ##1 !o_sda_oe)
		else $error("data line held after stop");
	AST_ALARM_SET: assert property (
		conv_done_r && over_high && !cfg_r[sensor_pkg::CFG_FQ] |=> o_alarm_oe)
		else $error("alarm not pulled on over-limit");
endmodule : smbus_temp_sensor_regs
`default_nettype wire

// >>> tb/smbus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bus master model
// ****************************************************************
// Clock moves in quarter steps of two system clocks (160 ns period)
module smbus_master_model (
	input wire logic i_clock,
	input wire logic i_sda_wire,
	output logic o_scl,
	output logic o_sda
);
	// Idle bus: both lines released, clock still between frames
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic quarter();
		repeat (2) @(posedge i_clock);
	endtask : quarter

	// Start or repeated start: data falls while clock is high
	task automatic send_start();
		o_sda <= 1'b1;
		quarter();
		o_scl <= 1'b1;
		quarter();
		o_sda <= 1'b0;
		quarter();
		o_scl <= 1'b0;
		quarter();
	endtask : send_start

	task automatic send_stop();
		o_sda <= 1'b0;
		quarter();
		o_scl <= 1'b1;
		quarter();
		o_sda <= 1'b1;
		quarter();
	endtask : send_stop

	// Data moves mid-low; read at a falling edge, away from updates
	task automatic bit_xfer(input logic b, output logic seen);
		o_sda <= b;
		quarter();
		o_scl <= 1'b1;
		quarter();
		@(negedge i_clock);
		seen = i_sda_wire;
		quarter();
		o_scl <= 1'b0;
		quarter();
	endtask : bit_xfer

	// Releases the line in the ninth bit so the slave can acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
		bit_xfer(1'b1, s);
		ack = ~s;
	endtask : wbyte

	// Last byte ends with a NACK so the slave lets go of the line
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
		bit_xfer(nack, s);
	endtask : rbyte
endmodule : smbus_master_model
`default_nettype wire

// >>> tb/smbus_temp_sensor_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_temp_sensor_regs_tb;
	localparam logic [6:0] DEV_ADDR = 7'h45;
	logic i_clock = 1'b0;
	logic i_reset = 1'b1;
	logic [12:0] die_temp = 13'h0190;
	logic [3:0] straps = 4'hD; // Bit 3 set, but this variant ignores it
	logic scl, m_sda, sda_wire, sda, sda_oe, al, al_oe, ot, ot_oe, a;
	logic [15:0] d;
	int failures = 0;
	int n_compared = 0;
	logic [7:0] rst_ptr [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
	logic [15:0] rst_val [4] = '{16'h0000, 16'h2580, 16'h0500, 16'h2800};

	always #10 i_clock = ~i_clock;
	// Pull-up on the data line; either party may pull it low
	assign sda_wire = m_sda & ~sda_oe;

	smbus_temp_sensor_regs #(.NUM_STRAPS(3), .ADDR_FIXED(7'h40),
		.CONV_CYCLES(200), .TIMEOUT_CYCLES(2000)) dut_u (
		.i_clock(i_clock), .i_reset(i_reset), .i_scl(scl),
		.i_sda(sda_wire), .i_addr_strap_bit0(straps[0]),
		.i_addr_strap_bit1(straps[1]), .i_addr_strap_bit2(straps[2]),
		.i_addr_strap_bit3(straps[3]), .i_die_temp(die_temp),
		.o_sda(sda), .o_sda_oe(sda_oe), .o_alarm(al), .o_alarm_oe(al_oe),
		.o_overheat_shutdown_out(ot), .o_overheat_shutdown_out_oe(ot_oe));

	smbus_master_model master_u (.i_clock(i_clock), .i_sda_wire(sda_wire),
		.o_scl(scl), .o_sda(m_sda));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	// nbytes 0 sets only the pointer; word data goes high byte first
	task automatic write_reg(input logic [7:0] ptr, input logic [15:0] v,
		input int nbytes);
		master_u.send_start();
		master_u.wbyte({DEV_ADDR, 1'b0}, a);
		check("addr ack", {15'h0000, a}, 16'h0001);
		master_u.wbyte(ptr, a);
		check("ptr ack", {15'h0000, a}, 16'h0001);
		if (nbytes == 2) master_u.wbyte(v[15:8], a);
		if (nbytes > 0) master_u.wbyte(v[7:0], a);
		master_u.send_stop();
	endtask : write_reg

	// Pointer then repeated start, or a read that reuses the old pointer
	task automatic read_reg(input logic set_ptr, input logic [7:0] ptr,
		input int nbytes, output logic [15:0] v);
		v = 16'h0000;
		master_u.send_start();
		if (set_ptr) begin
			master_u.wbyte({DEV_ADDR, 1'b0}, a);
			master_u.wbyte(ptr, a);
			master_u.send_start();
		end
		master_u.wbyte({DEV_ADDR, 1'b1}, a);
		check("read ack", {15'h0000, a}, 16'h0001);
		if (nbytes == 2) master_u.rbyte(1'b0, v[15:8]);
		master_u.rbyte(1'b1, v[7:0]);
		master_u.send_stop();
	endtask : read_reg

	task automatic new_temp(input logic [12:0] t, input int cycles);
		die_temp <= t;
		repeat (cycles) @(posedge i_clock);
	endtask : new_temp

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	// Values: 25 C 0x0190, -0.0625 C 0x1FFF, 80 C 0x0500, 50 C 0x0320
	initial begin
		repeat (8) @(posedge i_clock);
		i_reset <= 1'b0;
		repeat (10) @(posedge i_clock);
		check("oe idle", {13'h0000, sda_oe, al_oe, ot_oe}, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			read_reg(1'b1, rst_ptr[i], (i == 0) ? 1 : 2, d);
			check("reset value", d, rst_val[i]);
		end
		// Foreign address: straps set the low bits, so 0x44 is not us
		master_u.send_start();
		master_u.wbyte(8'h88, a);
		master_u.send_stop();
		check("foreign ack", {15'h0000, a}, 16'h0000);
		// Moving a strap moves the address: 0x44 now answers
		straps <= 4'hC;
		new_temp(13'h0190, 4);
		master_u.send_start();
		master_u.wbyte(8'h88, a);
		master_u.send_stop();
		check("strap ack", {15'h0000, a}, 16'h0001);
		straps <= 4'hD;
		new_temp(13'h0190, 4);
		new_temp(13'h0190, 250);
		read_reg(1'b1, 8'h00, 2, d);
		check("temp 25C", d, 16'h0C80);
		new_temp(13'h1FFF, 250);
		read_reg(1'b0, 8'h00, 2, d);
		check("temp neg", d, 16'hFFF9);
		// Temperature is read only; the write is acked and dropped
		write_reg(8'h00, 16'h1234, 2);
		read_reg(1'b1, 8'h00, 2, d);
		check("temp ro", d, 16'hFFF9);
		new_temp(13'h0500, 250);
		check("hot pins", {14'h0000, al_oe, ot_oe}, 16'h0003);
		read_reg(1'b0, 8'h00, 2, d);
		check("temp hot", d, 16'h2802);
		new_temp(13'h0190, 250);
		check("cool pins", {14'h0000, al_oe, ot_oe}, 16'h0000);
		write_reg(8'h04, 16'h1900, 2);
		read_reg(1'b1, 8'h04, 2, d);
		check("high limit", d, 16'h1900);
		new_temp(13'h0320, 250);
		check("new limit", {15'h0000, ot_oe}, 16'h0001);
		write_reg(8'h01, 16'h0088, 1);
		read_reg(1'b1, 8'h01, 1, d);
		check("config", d, 16'h0088);
		// Shutdown must freeze the result while the bus keeps working
		write_reg(8'h01, 16'h0001, 1);
		new_temp(13'h0190, 450);
		read_reg(1'b1, 8'h00, 2, d);
		check("frozen", d, 16'h1902);
		read_reg(1'b1, 8'h01, 1, d);
		check("shdn cfg", d, 16'h0001);
		write_reg(8'h01, 16'h0000, 1);
		new_temp(13'h0190, 450);
		read_reg(1'b1, 8'h00, 2, d);
		check("woken", d, 16'h0C80);
		// Clock held low mid-read: the timeout must free the data line
		master_u.send_start();
		master_u.wbyte({DEV_ADDR, 1'b1}, a);
		new_temp(13'h0190, 20);
		check("tmo drive", {15'h0000, sda_oe}, 16'h0001);
		new_temp(13'h0190, 2150);
		check("tmo free", {15'h0000, sda_oe}, 16'h0000);
		master_u.send_stop();
		check("pin levels", {13'h0000, sda, al, ot}, 16'h0000);
		give_verdict();
	end

	// Watchdog: a hung frame counts as a mismatch
	initial begin
		repeat (80000) @(posedge i_clock);
		failures++;
		$display("[ERR] watchdog expected finish seen hang");
		give_verdict();
	end
endmodule : smbus_temp_sensor_regs_tb
`default_nettype wire
